// [logic/stm_timer.sv]
// Standard timer: single-shot pulse output and input capture
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`include "stm_cfg.svh"
`default_nettype none
module stm_timer (
	// Clock and reset
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_i,
	// Register port
	input  wire stm_pkg::stm_bus_req_t bus_i,
	output logic [7:0]                 rdata_o,
	// Pins
	input  wire logic                  capture_input_pin_i,
	input  wire logic                  timer_ext_clock_pin_i,
	output logic                       pulse_o,
	output logic                       pulse_oe_o,
	// Interrupt
	output logic                       irq_o
);
	import stm_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic        timer_run_bit_ff;
	logic [1:0]  clk_sel_ff;
	stm_ctrl1_t  ctrl1_ff;
	logic [15:0] compare_a_value_ff;
	logic [7:0]  compare_p_value_ff;
	logic [15:0] cnt_ff;
	logic [1:0]  int_stat_ff;
	logic [1:0]  int_mask_ff;
	logic        run_d_ff;
	logic        ext_d_ff;
	logic        cap_smp_ff;
	logic        cap_ev_d_ff;
	logic        pulse_ff;
	logic        pulse_oe_ff;
	logic        irq_ff;
	logic [7:0]  rdata_ff;
	stm_run_st_t run_st_ff;
	logic [1:0]  pin_s;
	logic        tick;
	logic        pulse_mode;
	logic        capt_mode;
	logic        run_rise;
	logic        run_fall;
	logic        ext_trig;
	logic        a_match;
	logic        p_match;
	logic        cap_ev;
	logic        wr_ctrl0;
	logic [15:0] p_end;
	logic [1:0]  nxt_int_stat;
	logic        nxt_pulse;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic edge_ok(input logic [1:0] pinf, input logic lvl);
		logic ok;
		ok = 1'b0;
		case (pinf)
			`STM_PINF_RISE: ok = lvl;
			`STM_PINF_FALL: ok = ~lvl;
			`STM_PINF_BOTH: ok = 1'b1;
			default:        ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic is_wr(input stm_bus_req_t req, input logic [3:0] adr);
		return req.wr && (req.addr == adr);
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	stm_sync #(
		.W(2)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i    (rst_i),
		.pin_i    ({timer_ext_clock_pin_i, capture_input_pin_i}),
		.pin_o    (pin_s)
	);

	stm_tick u_tick (
		.clk_sys_i(clk_sys_i),
		.rst_i    (rst_i),
		.div_sel_i(clk_sel_ff),
		.tick_o   (tick)
	);

	// ----------------------------------------
	// Mode decode and events
	// ----------------------------------------
	// Single-shot only counts as such with pin function 11
	assign pulse_mode = (ctrl1_ff.op_mode_sel == `STM_MODE_PULSE) &&
	                    (ctrl1_ff.pin_function_sel == `STM_PINF_PULSE);
	assign capt_mode  = (ctrl1_ff.op_mode_sel == `STM_MODE_CAPT);
	assign run_rise   = timer_run_bit_ff & ~run_d_ff;
	assign run_fall   = ~timer_run_bit_ff & run_d_ff;
	assign ext_trig   = pin_s[1] & ~ext_d_ff;
	assign wr_ctrl0   = is_wr(bus_i, `STM_ADR_CTRL0);

	// Compare P against the high byte; zero wraps at 65536
	assign p_end      = {compare_p_value_ff, 8'h00} - 16'h0001;
	// A restart tick never matches the stale count
	assign a_match    = pulse_mode & timer_run_bit_ff & ~run_rise & tick &
	                    (cnt_ff == compare_a_value_ff);
	assign p_match    = capt_mode & timer_run_bit_ff & ~run_rise & tick &
	                    (cnt_ff == p_end);

	// Input sampled on each timer tick; short pulses between ticks are missed
	assign cap_ev     = capt_mode & tick & (pin_s[0] != cap_smp_ff) &
	                    edge_ok(ctrl1_ff.pin_function_sel, pin_s[0]);

	// ----------------------------------------
	// Pin edge history
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ext_d_ff   <= 1'b0;
			cap_smp_ff <= 1'b0;
		end else begin
			ext_d_ff <= pin_s[1];
			if (tick) begin
				cap_smp_ff <= pin_s[0];
			end
		end
	end

	// ----------------------------------------
	// Run bit
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			timer_run_bit_ff <= 1'b0;
			run_d_ff         <= 1'b0;
		end else begin
			run_d_ff <= timer_run_bit_ff;
			if (wr_ctrl0) begin
				timer_run_bit_ff <= bus_i.wdata[`STM_C0_RUN_BIT];
			end else if (pulse_mode && ext_trig) begin
				timer_run_bit_ff <= 1'b1;
			end else if (a_match) begin
				timer_run_bit_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			run_st_ff <= STM_RUN_IDLE;
		end else begin
			case (run_st_ff)
				STM_RUN_IDLE: begin
					if (run_rise) begin
						run_st_ff <= STM_RUN_ACTIVE;
					end
				end
				STM_RUN_ACTIVE: begin
					if (run_fall) begin
						run_st_ff <= STM_RUN_IDLE;
					end
				end
				default: begin
					run_st_ff <= STM_RUN_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= `STM_RST_WORD;
		end else if (run_rise) begin
			cnt_ff <= `STM_RST_WORD;
		end else if (a_match) begin
			// Single-shot stops on the compare A value
			cnt_ff <= cnt_ff;
		end else if (timer_run_bit_ff && tick) begin
			if (p_match) begin
				cnt_ff <= `STM_RST_WORD;
			end else begin
				cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Control and compare registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			clk_sel_ff         <= 2'h0;
			ctrl1_ff           <= '0;
			compare_p_value_ff <= `STM_RST_BYTE;
			int_mask_ff        <= 2'h0;
		end else begin
			if (wr_ctrl0) begin
				clk_sel_ff <= bus_i.wdata[`STM_C0_CLK_HI:`STM_C0_CLK_LO];
			end
			if (is_wr(bus_i, `STM_ADR_CTRL1)) begin
				ctrl1_ff <= stm_ctrl1_t'(bus_i.wdata);
			end
			if (is_wr(bus_i, `STM_ADR_COMPARE_P_VALUE)) begin
				compare_p_value_ff <= bus_i.wdata;
			end
			if (is_wr(bus_i, `STM_ADR_INT_MASK)) begin
				int_mask_ff <= bus_i.wdata[1:0];
			end
		end
	end

	// Capture overrides a software write in the same cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			compare_a_value_ff <= `STM_RST_WORD;
		end else if (cap_ev) begin
			compare_a_value_ff <= cnt_ff;
		end else begin
			if (is_wr(bus_i, `STM_ADR_COMPARE_A_VALUE_LO)) begin
				compare_a_value_ff[7:0] <= bus_i.wdata;
			end
			if (is_wr(bus_i, `STM_ADR_COMPARE_A_VALUE_HI)) begin
				compare_a_value_ff[15:8] <= bus_i.wdata;
			end
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	always_comb begin
		nxt_int_stat = int_stat_ff;
		if (is_wr(bus_i, `STM_ADR_INT_STAT)) begin
			nxt_int_stat = int_stat_ff & ~bus_i.wdata[1:0];
		end
		// Set wins over a clear in the same cycle
		if (a_match || cap_ev_d_ff) begin
			nxt_int_stat[`STM_INT_A_BIT] = 1'b1;
		end
		if (p_match) begin
			nxt_int_stat[`STM_INT_P_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			int_stat_ff <= 2'h0;
		end else begin
			int_stat_ff <= nxt_int_stat;
		end
	end

	// ----------------------------------------
	// Capture flag delay
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cap_ev_d_ff <= 1'b0;
		end else begin
			cap_ev_d_ff <= cap_ev;
		end
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_int_stat & int_mask_ff);
		end
	end

	// ----------------------------------------
	// Pulse output
	// ----------------------------------------
	always_comb begin
		nxt_pulse = pulse_ff;
		if (!pulse_mode) begin
			nxt_pulse = 1'b0;
		end else if (run_rise) begin
			nxt_pulse = ctrl1_ff.output_initial_level ^ ctrl1_ff.output_invert;
		end else if (run_fall) begin
			nxt_pulse = ~ctrl1_ff.output_initial_level ^ ctrl1_ff.output_invert;
		end else if (run_st_ff == STM_RUN_IDLE) begin
			nxt_pulse = ~ctrl1_ff.output_initial_level ^ ctrl1_ff.output_invert;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= nxt_pulse;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pulse_oe_ff <= 1'b0;
		end else begin
			pulse_oe_ff <= pulse_mode;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= `STM_RST_BYTE;
		end else if (bus_i.rd) begin
			case (bus_i.addr)
				`STM_ADR_CTRL0:    rdata_ff <= {2'h0, clk_sel_ff, timer_run_bit_ff, 3'h0};
				`STM_ADR_CTRL1:    rdata_ff <= ctrl1_ff;
				`STM_ADR_CNT_LO:   rdata_ff <= cnt_ff[7:0];
				`STM_ADR_CNT_HI:   rdata_ff <= cnt_ff[15:8];
				`STM_ADR_COMPARE_A_VALUE_LO:  rdata_ff <= compare_a_value_ff[7:0];
				`STM_ADR_COMPARE_A_VALUE_HI:  rdata_ff <= compare_a_value_ff[15:8];
				`STM_ADR_COMPARE_P_VALUE:     rdata_ff <= compare_p_value_ff;
				`STM_ADR_INT_STAT: rdata_ff <= {6'h00, int_stat_ff};
				`STM_ADR_INT_MASK: rdata_ff <= {6'h00, int_mask_ff};
				default:           rdata_ff <= `STM_RST_BYTE;
			endcase
		end else begin
			rdata_ff <= `STM_RST_BYTE;
		end
	end

	assign rdata_o    = rdata_ff;
	assign pulse_o    = pulse_ff;
	assign pulse_oe_o = pulse_oe_ff;
	assign irq_o      = irq_ff;
endmodule
`default_nettype wire

// [logic/stm_cfg.svh]
// Constants of the standard timer: offsets, fields, reset values, timing
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STM_ADR_CTRL0    4'h0
`define STM_ADR_CTRL1    4'h1
`define STM_ADR_CNT_LO   4'h2
`define STM_ADR_CNT_HI   4'h3
`define STM_ADR_COMPARE_A_VALUE_LO  4'h4
`define STM_ADR_COMPARE_A_VALUE_HI  4'h5
`define STM_ADR_COMPARE_P_VALUE     4'h6
`define STM_ADR_INT_STAT 4'h7
`define STM_ADR_INT_MASK 4'h8

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define STM_C0_RUN_BIT   3
`define STM_C0_CLK_LO    4
`define STM_C0_CLK_HI    5
`define STM_INT_A_BIT    0
`define STM_INT_P_BIT    1
`define STM_MODE_CAPT    2'h1
`define STM_MODE_PULSE   2'h2
`define STM_PINF_PULSE   2'h3
`define STM_PINF_RISE    2'h0
`define STM_PINF_FALL    2'h1
`define STM_PINF_BOTH    2'h2
`define STM_PINF_OFF     2'h3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define STM_RST_BYTE     8'h00
`define STM_RST_WORD     16'h0000
`define STM_DIV_SEL0     7'h04
`define STM_DIV_SEL1     7'h01
`define STM_DIV_SEL2     7'h10
`define STM_DIV_SEL3     7'h40
`define STM_CAPT_MIN_TCK 2

`endif

// [logic/stm_pkg.sv]
// Types of the standard timer
`default_nettype none
package stm_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} stm_bus_req_t;

	typedef struct packed {
		logic [1:0] op_mode_sel;
		logic [1:0] pin_function_sel;
		logic       output_initial_level;
		logic       output_invert;
		logic       duty_period_swap;
		logic       counter_clear_select;
	} stm_ctrl1_t;

	typedef enum logic [1:0] {
		STM_RUN_IDLE,
		STM_RUN_ACTIVE
	} stm_run_st_t;
endpackage
`default_nettype wire

// [logic/stm_sync.sv]
// Two-flop synchronisers for the timer pins
`timescale 1ns/100ps
`default_nettype none
module stm_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	// Pins in, synchronised out
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] pin_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk_sys_i or posedge rst_i) begin
				if (rst_i) begin
					meta_ff[g] <= 1'b0;
					sync_ff[g] <= 1'b0;
				end else begin
					meta_ff[g] <= pin_i[g];
					sync_ff[g] <= meta_ff[g];
				end
			end
		end
	endgenerate

	assign pin_o = sync_ff;
endmodule
`default_nettype wire

// [logic/stm_tick.sv]
// Timer clock tick generator from the system clock
`timescale 1ns/100ps
`include "stm_cfg.svh"
`default_nettype none
module stm_tick (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// Divider select and tick
	input  wire logic [1:0] div_sel_i,
	output logic            tick_o
);
	logic [6:0] div_cnt_ff;
	logic [6:0] div_val;
	logic       tick_ff;

	always_comb begin
		case (div_sel_i)
			2'h0:    div_val = `STM_DIV_SEL0;
			2'h1:    div_val = `STM_DIV_SEL1;
			2'h2:    div_val = `STM_DIV_SEL2;
			default: div_val = `STM_DIV_SEL3;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_ff <= 7'h00;
			tick_ff    <= 1'b0;
		end else if (div_cnt_ff >= div_val - 7'h01) begin
			div_cnt_ff <= 7'h00;
			tick_ff    <= 1'b1;
		end else begin
			div_cnt_ff <= div_cnt_ff + 7'h01;
			tick_ff    <= 1'b0;
		end
	end

	assign tick_o = tick_ff;
endmodule
`default_nettype wire

// [verif/stm_pin_model.sv]
// Far-side pin driver for the standard timer: capture input and trigger
`timescale 1ns/100ps
`default_nettype none
module stm_pin_model (
	// Clock
	input  wire logic clk_sys_i,
	// Pins towards the timer
	output logic      cap_o,
	output logic      trig_o
);
	initial begin
		cap_o  = 1'h0;
		trig_o = 1'h0;
	end

	// -----------------------------
	// Pin actions
	// -----------------------------
	task automatic set_cap(input logic lvl, input int hold);
		@(posedge clk_sys_i);
		cap_o <= lvl;
		repeat (hold) @(posedge clk_sys_i); // Held beyond two timer clocks except at the divider of 64
	endtask

	task automatic trigger(input int hold);
		@(posedge clk_sys_i);
		trig_o <= 1'h1; // Rising edge is the active trigger edge
		repeat (hold) @(posedge clk_sys_i);
		trig_o <= 1'h0;
	endtask
endmodule
`default_nettype wire

// [verif/stm_timer_sva.sv]
// Port-level assertions of the standard timer
`timescale 1ns/100ps
`default_nettype none
module stm_timer_sva (
	// Clock and reset
	input wire logic                  clk_sys_i,
	input wire logic                  rst_i,
	// Register port
	input wire stm_pkg::stm_bus_req_t bus_i,
	input wire logic [7:0]            rdata_o,
	// Pins and interrupt
	input wire logic                  capture_input_pin_i,
	input wire logic                  timer_ext_clock_pin_i,
	input wire logic                  pulse_o,
	input wire logic                  pulse_oe_o,
	input wire logic                  irq_o
);
	import stm_pkg::*;

	// -----------------------------
	// Shadow of software settings
	// -----------------------------
	logic [7:0] ctrl1_ff;
	logic [1:0] age_ff;
	logic [1:0] mask_ff;
	logic       stw_ff;
	logic       stw;
	logic       ready;
	logic       act;

	assign stw   = bus_i.wr && (bus_i.addr == 4'h7 || bus_i.addr == 4'h8);
	assign ready = age_ff == 2'h3 && ctrl1_ff[7:4] == 4'hb;
	assign act   = ctrl1_ff[3] ^ ctrl1_ff[2];

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl1_ff <= 8'h00;
			age_ff   <= 2'h3;
		end else if (bus_i.wr && bus_i.addr == 4'h1) begin
			ctrl1_ff <= bus_i.wdata;
			age_ff   <= 2'h0;
		end else if (age_ff != 2'h3) begin
			age_ff <= age_ff + 2'h1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			mask_ff <= 2'h0;
		else if (bus_i.wr && bus_i.addr == 4'h8)
			mask_ff <= bus_i.wdata[1:0];
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			stw_ff <= 1'h0;
		else
			stw_ff <= stw;
	end

	// -----------------------------
	// Properties
	// -----------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_run_wr(logic v);
		bus_i.wr && bus_i.addr == 4'h0 && bus_i.wdata[3] == v && ready;
	endsequence

	property p_oe_mode;
		age_ff == 2'h3 |-> pulse_oe_o == (ctrl1_ff[7:4] == 4'hb);
	endproperty
	property p_out_off;
		age_ff == 2'h3 && ctrl1_ff[7:4] != 4'hb |-> !pulse_o;
	endproperty
	property p_sw_start;
		s_run_wr(1'h1) ##0 pulse_o == !act |-> ##2 pulse_o == act;
	endproperty
	property p_sw_stop;
		s_run_wr(1'h0) ##0 pulse_o == act |-> ##2 pulse_o == !act;
	endproperty
	property p_trig;
		$rose(timer_ext_clock_pin_i) && ready && pulse_o == !act |-> ##[3:6] pulse_o == act;
	endproperty
	property p_cap;
		$rose(capture_input_pin_i) && ctrl1_ff[7:4] == 4'h4 && age_ff == 2'h3 && mask_ff[0] |-> ##[2:90] irq_o;
	endproperty
	property p_cap_off;
		$changed(capture_input_pin_i) && ctrl1_ff[7:4] == 4'h7 && age_ff == 2'h3 && mask_ff == 2'h1 && !irq_o
			|-> ##4 !irq_o [*8];
	endproperty
	property p_irq_hold;
		irq_o && !stw && !stw_ff |=> irq_o;
	endproperty

	a_oe_mode: assert property (p_oe_mode) else $error("pulse enable disagrees with mode");
	a_out_off: assert property (p_out_off) else $error("pulse driven outside single-shot");
	a_sw_start: assert property (p_sw_start) else $error("no leading edge after run write");
	a_sw_stop: assert property (p_sw_stop) else $error("no trailing edge after run clear");
	a_trig: assert property (p_trig) else $error("trigger did not start pulse");
	a_cap: assert property (p_cap) else $error("capture edge raised no interrupt");
	a_cap_off: assert property (p_cap_off) else $error("capture while disabled");
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without write");
endmodule

bind stm_timer stm_timer_sva u_sva (
	.clk_sys_i             (clk_sys_i),
	.rst_i                 (rst_i),
	.bus_i                 (bus_i),
	.rdata_o               (rdata_o),
	.capture_input_pin_i   (capture_input_pin_i),
	.timer_ext_clock_pin_i (timer_ext_clock_pin_i),
	.pulse_o               (pulse_o),
	.pulse_oe_o            (pulse_oe_o),
	.irq_o                 (irq_o)
);
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench of the standard timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
	$display("Error %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
	import stm_pkg::*;

	logic         clk_sys_i;
	logic         rst_i;
	stm_bus_req_t bus;
	logic [7:0]   rdata;
	logic         cap;
	logic         trig;
	logic         pulse;
	logic         pulse_oe;
	logic         irq;
	int           n_fail;
	int           comparisons;
	int           n;
	logic [7:0]   d;
	logic [15:0]  compare_a_value;
	logic         act;

	stm_timer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
		.capture_input_pin_i(cap), .timer_ext_clock_pin_i(trig), .pulse_o(pulse),
		.pulse_oe_o(pulse_oe), .irq_o(irq));
	stm_pin_model u_pins (.clk_sys_i(clk_sys_i), .cap_o(cap), .trig_o(trig));

	initial begin
		clk_sys_i = 1'h0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// -----------------------------
	// Bus, waits, expectations
	// -----------------------------
	task automatic end_sim;
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
		bus.addr  <= adr;
		bus.wdata <= dat;
		bus.wr    <= 1'h1;
		@(posedge clk_sys_i);
		bus.wr <= 1'h0;
		@(posedge clk_sys_i);
	endtask

	task automatic rd(input logic [3:0] adr, output logic [7:0] dat);
		bus.addr <= adr;
		bus.rd   <= 1'h1;
		@(posedge clk_sys_i);
		bus.rd <= 1'h0;
		#1;
		dat = rdata;
		@(posedge clk_sys_i);
	endtask

	task automatic wait_irq(input int lim, output int cnt);
		cnt = 0;
		while (irq !== 1'h1 && cnt < lim) begin
			@(posedge clk_sys_i);
			#1;
			cnt++;
		end
		if (irq !== 1'h1) begin
			n_fail++;
			$display("Error %0t: interrupt wait ran out", $time);
			end_sim();
		end
	endtask

	function automatic logic exp_cap(input logic [1:0] f, input logic lvl);
		return (f == 2'h2) || (f == 2'h0 && lvl) || (f == 2'h1 && !lvl);
	endfunction

	// -----------------------------
	// Scenarios
	// -----------------------------
	initial begin
		rst_i       = 1'h1;
		bus         = '0;
		n_fail      = 0;
		comparisons = 0;
		void'($urandom(32'h762af1b8));
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		@(posedge clk_sys_i);
		// Reset values, unmapped place
		wr(4'hf, 8'hff);
		for (int i = 0; i < 10; i++) begin
			rd((i == 9) ? 4'hf : 4'(i), d);
			`CHK(d, 8'h00)
		end
		// Single-shot, software start, compare A stop
		d    = {4'hb, 2'($urandom), 2'h3};
		act  = d[3] ^ d[2];
		compare_a_value = 16'h104 + (16'($urandom) & 16'h003f);
		wr(4'h1, d);
		wr(4'h8, 8'h03);
		wr(4'h6, 8'h01);
		wr(4'h4, compare_a_value[7:0]);
		wr(4'h5, compare_a_value[15:8]);
		wr(4'h0, 8'h10);
		wr(4'h7, 8'h03);
		#1;
		`CHK(pulse_oe, 1'h1)
		`CHK(pulse, !act)
		wr(4'h0, 8'h18);
		#1;
		`CHK(pulse, act)
		wait_irq(400, n);
		rd(4'h7, d);
		`CHK(d, 8'h01)
		`CHK(pulse, !act)
		rd(4'h0, d);
		`CHK(d[3], 1'h0)
		repeat (20) @(posedge clk_sys_i);
		rd(4'h2, d);
		`CHK(d, compare_a_value[7:0])
		rd(4'h3, d);
		`CHK(d, compare_a_value[15:8])
		// Trigger start, software stop
		wr(4'h7, 8'h03);
		u_pins.trigger(6);
		#1;
		`CHK(pulse, act)
		rd(4'h0, d);
		`CHK(d[3], 1'h1)
		wr(4'h0, 8'h10);
		#1;
		`CHK(pulse, !act)
		rd(4'h7, d);
		`CHK(d, 8'h00)
		// Capture, every edge selection
		wr(4'h8, 8'h01);
		for (int f = 0; f < 4; f++) begin
			logic [7:0] c1;
			logic [7:0] c2;
			logic [7:0] a;
			wr(4'h1, {2'h1, 2'(f), 4'($urandom)});
			wr(4'h0, 8'h00);
			wr(4'h0, {2'h0, 2'(f), 4'h8});
			wr(4'h7, 8'h03);
			#1;
			`CHK(pulse_oe, 1'h0)
			`CHK(pulse, 1'h0)
			for (int l = 1; l >= 0; l--) begin
				rd(4'h2, c1);
				u_pins.set_cap(1'(l), 80);
				rd(4'h7, d);
				`CHK(d[0], exp_cap(2'(f), 1'(l)))
				`CHK(irq, exp_cap(2'(f), 1'(l)))
				rd(4'h4, a);
				rd(4'h2, c2);
				`CHK(c2 > c1, 1'h1)
				if (exp_cap(2'(f), 1'(l)))
					`CHK(a >= c1 && a <= c2, 1'h1)
				wr(4'h7, 8'h03);
			end
		end
		// Compare P bound, interrupt mask and clear
		wr(4'h1, 8'h70);
		wr(4'h8, 8'h02);
		wr(4'h0, 8'h00);
		wr(4'h7, 8'h03);
		wr(4'h0, 8'h18);
		wait_irq(400, n);
		`CHK(n >= 250 && n <= 262, 1'h1)
		rd(4'h7, d);
		`CHK(d, 8'h02)
		rd(4'h3, d);
		`CHK(d, 8'h00)
		wr(4'h8, 8'h00);
		#1;
		`CHK(irq, 1'h0)
		wr(4'h8, 8'h02);
		#1;
		`CHK(irq, 1'h1)
		wr(4'h7, 8'h02);
		#1;
		`CHK(irq, 1'h0)
		end_sim();
	end
endmodule
`default_nettype wire
